// [src/fiber_sync_trigger_router.sv]
`timescale 1ns/10ps
module fiber_sync_trigger_router
  import fiber_trig_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Local trigger sources
  input  wire logic [3:0]  io_pin,
  input  wire logic        front_key_press,
  input  wire logic        gpib_group_trigger,
  input  wire logic        scpi_bus_trigger,
  input  wire logic        scope_trigger,
  // Ring sync status pin
  input  wire logic        sync_normal,
  // Network words from the ring receiver
  input  wire logic [31:0] fiber_rx_word,
  input  wire logic        fiber_rx_valid,
  // Network words to the ring transmitter
  output logic [31:0]      fiber_tx_word,
  output logic             fiber_tx_valid,
  // Trigger pulses to the unit
  output logic             unit_trigger,
  output logic             sweep_start_trigger,
  output logic             sweep_step_trigger
);

  role_t       role;          // Ring role
  logic [7:0]  map_en;        // Mapping switches, bit 0 is line 25
  logic [3:0]  io_trig_cfg;   // IO pin configured as trigger input
  logic [21:0] select;        // Trigger source selectors
  logic [31:0] rx_last;       // Last received word, for software
  logic [7:0]  pending;       // Local events waiting for a word slot
  logic [31:0] fwd_pending;   // Ring lines waiting to be repeated
  logic [7:0]  slot_cnt;      // Word slot timer
  logic        slot;          // Word slot boundary this cycle
  logic        sync_meta;     // Sync pin, first stage only
  logic        sync_ok;       // Sync pin, synchronised
  logic        active;        // Unit takes part in triggering
  logic [3:0]  io_fall;       // Falling edges on IO pins
  logic [7:0]  events;        // Raw local events per mapping
  logic [7:0]  accepted;      // Events that may reach the network

  // AXI internal state
  logic        aw_held;       // Write address captured
  logic        w_held;        // Write data captured
  logic [7:0]  wr_addr;       // Captured write address
  logic [31:0] wr_data;       // Captured write data
  logic [3:0]  wr_strb;       // Captured byte enables
  logic        aw_take;       // Address handshake now
  logic        w_take;        // Data handshake now
  logic        do_write;      // Both halves present, apply write
  logic        next_aw_held;  // Address captured next cycle
  logic        next_w_held;   // Data captured next cycle
  logic        ar_take;       // Read handshake now
  logic        next_rvalid;   // Read answer pending next cycle
  logic [31:0] wmask;         // Byte-lane mask
  logic        cfg_allowed;   // Configuration not refused
  logic        wr_refused;    // Current write refused
  logic [31:0] rd_word;       // Read mux
  logic        rd_err;        // Unmapped read address

  // Four IO pins each get a synchroniser and edge detector
  genvar gi;
  generate
    for (gi = 0; gi < IO_COUNT; gi++) begin : g_io
      pin_fall_detect u_fall (
        .clk  (clk),
        .rst  (rst),
        .pin  (io_pin[gi]),
        .fall (io_fall[gi])
      );
    end
  endgenerate

  // Sync status comes from outside, so it passes two flops
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_meta <= 1'b0;
      sync_ok   <= 1'b0;
    end else begin
      sync_meta <= sync_normal;
      sync_ok   <= sync_meta;
    end
  end

  // Only a master or slave with normal sync takes part
  assign active = (role != ROLE_STANDALONE) && sync_ok;

  // Local events; IO edges count only on pins set as trigger inputs
  assign events[0] = io_fall[0] & io_trig_cfg[0];
  assign events[1] = io_fall[1] & io_trig_cfg[1];
  assign events[2] = io_fall[2] & io_trig_cfg[2];
  assign events[3] = io_fall[3] & io_trig_cfg[3];
  assign events[4] = front_key_press;
  assign events[5] = gpib_group_trigger;
  assign events[6] = scpi_bus_trigger;
  assign events[7] = scope_trigger;

  // A switched-off mapping never lets its event through
  assign accepted = events & map_en & {MAP_COUNT{active}};

  // Word slot timer; runs always so idle words keep the ring clocked
  always_ff @(posedge clk) begin
    if (rst) begin
      slot_cnt <= 8'h00;
    end else if (slot) begin
      slot_cnt <= 8'h00;
    end else begin
      slot_cnt <= slot_cnt + 8'h01;
    end
  end
  assign slot = (slot_cnt == WORD_LAST);

  // Pending events: set wins over the slot clear so none is lost
  always_ff @(posedge clk) begin
    if (rst) begin
      pending <= 8'h00;
    end else if (slot) begin
      pending <= accepted;
    end else begin
      pending <= pending | accepted;
    end
  end

  // Slaves repeat ring lines downstream; the master ends the loop
  // so a trigger does not circulate forever
  always_ff @(posedge clk) begin
    if (rst) begin
      fwd_pending <= 32'h00000000;
    end else if (slot) begin
      if (fiber_rx_valid && active && role == ROLE_SLAVE) begin
        fwd_pending <= fiber_rx_word;
      end else begin
        fwd_pending <= 32'h00000000;
      end
    end else if (fiber_rx_valid && active && role == ROLE_SLAVE) begin
      fwd_pending <= fwd_pending | fiber_rx_word;
    end
  end

  // Transmit one word per slot; each line stands for that word only
  always_ff @(posedge clk) begin
    if (rst) begin
      fiber_tx_word  <= 32'h00000000;
      fiber_tx_valid <= 1'b0;
    end else begin
      fiber_tx_valid <= slot;
      if (slot) begin
        // Mapped lines occupy the top byte, lines 25..32
        fiber_tx_word <= {(pending & map_en), 24'h000000} | fwd_pending;
      end else begin
        fiber_tx_word <= 32'h00000000;
      end
    end
  end

  // Received word kept for status reads
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_last <= 32'h00000000;
    end else if (fiber_rx_valid) begin
      rx_last <= fiber_rx_word;
    end
  end

  // Selected lines trigger the unit and the sweep engine
  always_ff @(posedge clk) begin
    if (rst) begin
      unit_trigger        <= 1'b0;
      sweep_start_trigger <= 1'b0;
      sweep_step_trigger  <= 1'b0;
    end else begin
      unit_trigger <= fiber_rx_valid && active && select[SEL_NORM_POS + SEL_EN_BIT]
                      && fiber_rx_word[select[SEL_NORM_POS +: 5]];
      sweep_start_trigger <= fiber_rx_valid && active && select[SEL_START_POS + SEL_EN_BIT]
                             && fiber_rx_word[select[SEL_START_POS +: 5]];
      sweep_step_trigger <= fiber_rx_valid && active && select[SEL_STEP_POS + SEL_EN_BIT]
                            && fiber_rx_word[select[SEL_STEP_POS +: 5]];
    end
  end

  // AXI write channel handshakes
  assign aw_take      = s_axi_awvalid & s_axi_awready;
  assign w_take       = s_axi_wvalid & s_axi_wready;
  assign do_write     = aw_held & w_held & ~s_axi_bvalid;
  assign next_aw_held = (aw_held | aw_take) & ~do_write;
  assign next_w_held  = (w_held | w_take) & ~do_write;
  assign wmask        = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  assign cfg_allowed  = (role != ROLE_STANDALONE);

  // Refusal: map or select while standalone, role value 3, bad normal line, any other address
  always_comb begin
    wr_refused = 1'b0;
    case (wr_addr)
      ADDR_ROLE:   wr_refused = (wr_data[1:0] == 2'h3);
      ADDR_MAP:    wr_refused = ~cfg_allowed;
      ADDR_IOCFG:  wr_refused = 1'b0;
      ADDR_SELECT: wr_refused = ~cfg_allowed
                   || (wr_data[SEL_NORM_POS + SEL_EN_BIT] && wr_strb[0]
                       && wr_data[SEL_NORM_POS +: 5] < FIRST_MAPPED);
      default:     wr_refused = 1'b1;
    endcase
  end

  // Capture address and data independently, in either order
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      wr_addr       <= 8'h00;
      wr_data       <= 32'h00000000;
      wr_strb       <= 4'h0;
    end else begin
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      s_axi_awready <= ~next_aw_held;
      s_axi_wready  <= ~next_w_held;
      if (aw_take) begin
        wr_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (w_take) begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
    end
  end

  // Write response follows the applied write
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_refused ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Role register; reset leaves the unit standalone
  always_ff @(posedge clk) begin
    if (rst) begin
      role <= ROLE_STANDALONE;
    end else if (do_write && !wr_refused && wr_addr == ADDR_ROLE && wr_strb[0]) begin
      role <= role_t'(wr_data[1:0]);
    end
  end

  // Mapping switches; all off after reset, writes refused when standalone
  always_ff @(posedge clk) begin
    if (rst) begin
      map_en <= MAP_RESET;
    end else if (do_write && !wr_refused && wr_addr == ADDR_MAP) begin
      map_en <= (map_en & ~wmask[7:0]) | (wr_data[7:0] & wmask[7:0]);
    end
  end

  // IO pin function: trigger input or not
  always_ff @(posedge clk) begin
    if (rst) begin
      io_trig_cfg <= IOCFG_RESET;
    end else if (do_write && !wr_refused && wr_addr == ADDR_IOCFG) begin
      io_trig_cfg <= (io_trig_cfg & ~wmask[3:0]) | (wr_data[3:0] & wmask[3:0]);
    end
  end

  // Source selectors for normal, sweep start and sweep step
  always_ff @(posedge clk) begin
    if (rst) begin
      select <= SELECT_RESET;
    end else if (do_write && !wr_refused && wr_addr == ADDR_SELECT) begin
      select <= (select & ~wmask[21:0]) | (wr_data[21:0] & wmask[21:0]);
    end
  end

  // Read mux; unmapped addresses read zero with an error
  always_comb begin
    rd_word = 32'h00000000;
    rd_err  = 1'b0;
    case ({s_axi_araddr[7:2], 2'b00})
      ADDR_ROLE:   rd_word[1:0] = role;
      ADDR_MAP:    rd_word[7:0] = map_en;
      ADDR_IOCFG:  rd_word[3:0] = io_trig_cfg;
      ADDR_SELECT: rd_word[21:0] = select;
      ADDR_STATUS: begin
        rd_word[ST_SYNC_POS]        = sync_ok;
        rd_word[ST_ACTIVE_POS]      = active;
        rd_word[ST_PEND_POS +: 8]   = pending;
      end
      ADDR_RXLAST: rd_word = rx_last;
      default:     rd_err = 1'b1;
    endcase
  end

  // Read channel: one read at a time, answer the cycle after acceptance
  assign ar_take     = s_axi_arvalid & s_axi_arready;
  assign next_rvalid = (s_axi_rvalid & ~s_axi_rready) | ar_take;

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_rvalid  <= next_rvalid;
      s_axi_arready <= ~next_rvalid;
      if (ar_take) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

endmodule

// [src/fiber_trig_pkg.sv]
package fiber_trig_pkg;

  // Network word and bus widths
  localparam int          LINE_COUNT   = 32;
  localparam int          MAP_COUNT    = 8;
  localparam int          IO_COUNT     = 4;
  // First mapped line index (line 25 is bit 24)
  localparam logic [4:0]  FIRST_MAPPED = 5'h18;

  // Network word pacing
  localparam int          CLK_PERIOD_NS   = 8;
  localparam int          FIBER_WORD_NS   = 80;
  localparam int          WORD_CYCLES_RAW = FIBER_WORD_NS / CLK_PERIOD_NS;
  localparam int          WORD_CYCLES     = (WORD_CYCLES_RAW < 1) ? 1 : WORD_CYCLES_RAW;
  localparam logic [7:0]  WORD_LAST       = 8'(WORD_CYCLES - 1);

  // Register byte offsets
  localparam logic [7:0]  ADDR_ROLE   = 8'h00;
  localparam logic [7:0]  ADDR_MAP    = 8'h04;
  localparam logic [7:0]  ADDR_IOCFG  = 8'h08;
  localparam logic [7:0]  ADDR_SELECT = 8'h0C;
  localparam logic [7:0]  ADDR_STATUS = 8'h10;
  localparam logic [7:0]  ADDR_RXLAST = 8'h14;

  // Select register fields: 5-bit line index plus enable bit each
  localparam int          SEL_NORM_POS  = 0;
  localparam int          SEL_START_POS = 8;
  localparam int          SEL_STEP_POS  = 16;
  localparam int          SEL_EN_BIT    = 5;

  // Status register fields
  localparam int          ST_SYNC_POS    = 0;
  localparam int          ST_ACTIVE_POS  = 1;
  localparam int          ST_PEND_POS    = 8;

  // Reset values
  localparam logic [7:0]  MAP_RESET    = 8'h00;
  localparam logic [3:0]  IOCFG_RESET  = 4'h0;
  localparam logic [21:0] SELECT_RESET = 22'h000000;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Unit role on the ring
  typedef enum logic [1:0] {
    ROLE_STANDALONE,
    ROLE_MASTER,
    ROLE_SLAVE
  } role_t;

endpackage

// [src/pin_fall_detect.sv]
`timescale 1ns/10ps
// Synchronises one pin and pulses on its falling edge
module pin_fall_detect
  import fiber_trig_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      fall
);

  logic meta;   // First stage, read only by the second stage
  logic stable; // Second stage, safe to use
  logic prev;   // Previous stable level

  // Two-stage synchroniser then edge compare; reset idles high so no false edge
  always_ff @(posedge clk) begin
    if (rst) begin
      meta   <= 1'b1;
      stable <= 1'b1;
      prev   <= 1'b1;
      fall   <= 1'b0;
    end else begin
      meta   <= pin;
      stable <= meta;
      prev   <= stable;
      fall   <= prev & ~stable;
    end
  end

endmodule

// [test/fiber_router_asserts.sv]
`timescale 1ns/10ps
// Pin-level watch on pacing, gating and handshakes
module fiber_router_asserts (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_arready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        sync_normal,
  input wire logic        fiber_rx_valid,
  input wire logic [31:0] fiber_tx_word,
  input wire logic        fiber_tx_valid,
  input wire logic        unit_trigger,
  input wire logic        sweep_start_trigger,
  input wire logic        sweep_step_trigger
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  word_idle_a: assert property (!fiber_tx_valid |-> fiber_tx_word == 32'h0)
    else $error("line set outside its word");
  slot_pace_a: assert property (fiber_tx_valid |=> (!fiber_tx_valid) [*8] ##1
    !fiber_tx_valid ##1 fiber_tx_valid) else $error("word slots not ten cycles apart");
  unit_cause_a: assert property (unit_trigger |-> $past(fiber_rx_valid))
    else $error("unit trigger without a word");
  start_cause_a: assert property (sweep_start_trigger |-> $past(fiber_rx_valid))
    else $error("sweep start without a word");
  step_cause_a: assert property (sweep_step_trigger |-> $past(fiber_rx_valid))
    else $error("sweep step without a word");
  // Synchroniser delay is covered by five low samples
  sync_gate_a: assert property ((!sync_normal) [*5] |=> !unit_trigger)
    else $error("trigger while sync lost");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  bresp_taken_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  reset_idle_a: assert property ($fell(rst) |=> s_axi_awready && s_axi_arready
    && fiber_tx_word == 32'h0) else $error("not idle after reset");
endmodule

bind fiber_sync_trigger_router fiber_router_asserts i_chk (
  .clk(clk), .rst(rst), .s_axi_awready(s_axi_awready), .s_axi_arready(s_axi_arready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .sync_normal(sync_normal), .fiber_rx_valid(fiber_rx_valid),
  .fiber_tx_word(fiber_tx_word), .fiber_tx_valid(fiber_tx_valid),
  .unit_trigger(unit_trigger), .sweep_start_trigger(sweep_start_trigger),
  .sweep_step_trigger(sweep_step_trigger));

// [test/ring_peer_model.sv]
`timescale 1ns/10ps
// Ring peers: relay the unit's words back, or act as master placing new ones
module ring_peer_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        relay_en,
  input  wire logic        inject,
  input  wire logic [31:0] inject_word,
  input  wire logic [31:0] tx_word,
  input  wire logic        tx_valid,
  output logic [31:0]      rx_word,
  output logic             rx_valid
);
  logic [2:0][31:0] pipe_w;  // Words in flight
  logic [2:0]       pipe_v;  // Their valid flags
  logic             go;      // A word enters the ring
  logic [31:0]      next_w;  // The word entering
  // Relayed words and the master's own share one ring
  assign go = inject | (relay_en & tx_valid);
  assign next_w = (inject ? inject_word : 32'h0) | (relay_en ? tx_word : 32'h0);
  // Ring delay; idle line toggles so stale data never passes for a word
  always_ff @(posedge clk) begin
    if (rst) begin
      pipe_v   <= 3'h0;
      pipe_w   <= '0;
      rx_valid <= 1'b0;
      rx_word  <= 32'h0;
    end else begin
      pipe_v   <= {pipe_v[1:0], go};
      pipe_w   <= {pipe_w[1:0], next_w};
      rx_valid <= pipe_v[2];
      rx_word  <= pipe_v[2] ? pipe_w[2] : ~rx_word;
    end
  end
endmodule

// [test/testbench.sv]
`timescale 1ns/10ps
// Drives the router over AXI4-Lite and a ring peer
module testbench
  import fiber_trig_pkg::*;
;
  logic        clk, rst, sync_normal, relay_en, inject;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, src;
  logic [31:0] s_axi_wdata, s_axi_rdata, fiber_rx_word, fiber_tx_word, inject_word;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        fiber_rx_valid, fiber_tx_valid;
  logic        unit_trigger, sweep_start_trigger, sweep_step_trigger;
  int          fails, cmp_count, n_unit, n_start, n_step;

  // Sources ride on src: IO pins idle high and fall to trigger
  fiber_sync_trigger_router i_dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .io_pin(~src[3:0]), .front_key_press(src[4]), .gpib_group_trigger(src[5]),
    .scpi_bus_trigger(src[6]), .scope_trigger(src[7]), .sync_normal, .fiber_rx_word,
    .fiber_rx_valid, .fiber_tx_word, .fiber_tx_valid, .unit_trigger,
    .sweep_start_trigger, .sweep_step_trigger);
  ring_peer_model i_peer (.clk, .rst, .relay_en, .inject, .inject_word,
    .tx_word(fiber_tx_word), .tx_valid(fiber_tx_valid), .rx_word(fiber_rx_word),
    .rx_valid(fiber_rx_valid));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Tally trigger pulses towards the unit
  always @(posedge clk) begin
    if (unit_trigger === 1'b1) n_unit++;
    if (sweep_start_trigger === 1'b1) n_start++;
    if (sweep_step_trigger === 1'b1) n_step++;
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Stuck handshake ends the run as a mismatch
  task automatic guard(input logic done);
    if (!done) begin
      fails++;
      close_out();
    end
  endtask
  // Bready stands from the request on, so the answer is taken at the edge it is seen
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int   n;
    logic got;
    n = 0;
    got = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!got && n < 50) begin
      @(posedge clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        got = 1'b1;
        s_axi_bready <= 1'b0;
        chk("bresp", er, s_axi_bresp);
      end
    end
    guard(got);
  endtask
  // Read data and response are taken at the edge where rvalid is seen high
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int   n;
    logic got;
    n = 0;
    got = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got && n < 50) begin
      @(posedge clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        got = 1'b1;
        s_axi_rready <= 1'b0;
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
      end
    end
    guard(got);
  endtask
  task automatic fire(input int i);
    @(posedge clk);
    src <= 8'h01 << i;
    @(posedge clk);
    src <= 8'h00;
  endtask
  // Far master places one word on the ring
  task automatic ring_put(input logic [31:0] wd);
    @(posedge clk);
    inject_word <= wd;
    inject <= 1'b1;
    @(posedge clk);
    inject <= 1'b0;
  endtask
  // First nonzero word within four slots, else zero
  task automatic get_tx(output logic [31:0] w);
    int n;
    w = 32'h0;
    n = 0;
    while (w === 32'h0 && n < 40) begin
      @(posedge clk);
      n++;
      if (fiber_tx_valid === 1'b1) w = fiber_tx_word;
    end
  endtask

  task automatic sc_standalone();
    axi_rd(ADDR_ROLE, 32'h0, RESP_OKAY);
    axi_rd(ADDR_SELECT, 32'h0, RESP_OKAY);
    axi_rd(8'h18, 32'h0, RESP_SLVERR);
    axi_wr(ADDR_MAP, 32'hFF, RESP_SLVERR);
    axi_wr(ADDR_SELECT, 32'h3C, RESP_SLVERR);
    axi_rd(ADDR_MAP, 32'h0, RESP_OKAY);
    axi_wr(ADDR_ROLE, 32'h3, RESP_SLVERR);
    axi_rd(ADDR_ROLE, 32'h0, RESP_OKAY);
  endtask
  task automatic sc_master();
    logic [31:0] w;
    axi_wr(ADDR_ROLE, 32'h1, RESP_OKAY);
    axi_wr(ADDR_MAP, 32'hFF, RESP_OKAY);
    axi_wr(ADDR_IOCFG, 32'hF, RESP_OKAY);
    axi_wr(ADDR_SELECT, 32'h3C, RESP_OKAY);
    axi_wr(ADDR_SELECT, 32'h23, RESP_SLVERR);
    axi_rd(ADDR_SELECT, 32'h3C, RESP_OKAY);
    axi_rd(ADDR_STATUS, 32'h3, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      fire(i);
      get_tx(w);
      chk("tx line", 32'h1 << (24 + i), w);
      get_tx(w);
      chk("tx repeat", 32'h0, w);
    end
    chk("unit trig", 32'h1, n_unit);
  endtask
  task automatic sc_gate();
    logic [31:0] w;
    axi_wr(ADDR_MAP, 32'h7F, RESP_OKAY);
    fire(7);
    get_tx(w);
    chk("tx map off", 32'h0, w);
    axi_wr(ADDR_IOCFG, 32'hE, RESP_OKAY);
    fire(0);
    get_tx(w);
    chk("tx io off", 32'h0, w);
    sync_normal <= 1'b0;
    repeat (6) @(posedge clk);
    axi_rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    fire(4);
    ring_put(32'h10000000);
    get_tx(w);
    chk("tx sync low", 32'h0, w);
    sync_normal <= 1'b1;
    chk("unit trig", 32'h1, n_unit);
  endtask
  // Far master places lines 29, 32 and 4 on the ring
  task automatic sc_slave();
    logic [31:0] w;
    relay_en <= 1'b0;
    axi_wr(ADDR_ROLE, 32'h2, RESP_OKAY);
    axi_wr(ADDR_SELECT, 32'h3F233C, RESP_OKAY);
    ring_put(32'h90000008);
    get_tx(w);
    chk("tx relay", 32'h90000008, w);
    chk("unit trig", 32'h2, n_unit);
    chk("start trig", 32'h1, n_start);
    chk("step trig", 32'h1, n_step);
    axi_rd(ADDR_RXLAST, 32'h90000008, RESP_OKAY);
  endtask
  // Reset in mid-run must drop the programmed role and mappings
  task automatic sc_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    axi_rd(ADDR_ROLE, 32'h0, RESP_OKAY);
    axi_rd(ADDR_MAP, 32'h0, RESP_OKAY);
  endtask

  initial begin
    {rst, sync_normal, relay_en} = 3'h7;
    {inject, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, src} = 24'h0;
    {s_axi_wdata, inject_word} = 64'h0;
    s_axi_wstrb = 4'hF;
    {fails, cmp_count} = 64'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    sc_standalone();
    sc_master();
    sc_gate();
    sc_slave();
    sc_reset();
    close_out();
  end
endmodule
